// ==== twt_cfg.svh ====
// Constants of the two-wire target block: register offsets, bit positions,
// status codes and reset values.
// Assumes inclusion by the core module only.
//
// Contract
// - GC data acked: flag, $90, ack per enable
// - GC data nacked: $98, then leave addressed
// - Stop/restart while addressed: $A0, unaddressed
// - Ack enable zero: no address recognised
// - Ack enable one: own address, GC if enabled
// - Start request at clear: START when free
// - Match upper seven address bits only
// - Address LSB enables general call $00
// - Direction bit one transmits, zero receives
// - Address acked: set flag, valid status
// - Arbitration lost then read: code $B0
// - Ack enable cleared: last byte, $C0/$C8
// - After last byte release SDA, ignore master
// - Ack enable zero still monitors the bus
// - Asleep: match address on SCL, wake part
// - Hold SCL low until flag cleared
// - Data register not updated while asleep
// - GC clear without ack enable: NOT ACK
// - Own data nacked: $88, then leave
// - Own read acked: $A8, send data register
`ifndef TWT_CFG_SVH
`define TWT_CFG_SVH

// -------------------------------------------------------------------------
// Register offsets
// -------------------------------------------------------------------------
`define TWT_OFS_CTRL   2'h0
`define TWT_OFS_STAT   2'h1
`define TWT_OFS_DATA   2'h2
`define TWT_OFS_OWN    2'h3

// -------------------------------------------------------------------------
// Control and own-address register bit positions
// -------------------------------------------------------------------------
`define TWT_CB_FLAG    7
`define TWT_CB_ACKEN   6
`define TWT_CB_STA     5
`define TWT_CB_STO     4
`define TWT_CB_WC      3
`define TWT_CB_EN      2
`define TWT_CB_IE      0
`define TWT_OWN_GCE    0

// -------------------------------------------------------------------------
// Status codes and reset values
// -------------------------------------------------------------------------
`define TWT_SC_RXA_OWN 8'h60
`define TWT_SC_RXA_ARB 8'h68
`define TWT_SC_GC      8'h70
`define TWT_SC_GC_ARB  8'h78
`define TWT_SC_RX_ACK  8'h80
`define TWT_SC_RX_NAK  8'h88
`define TWT_SC_GC_ACK  8'h90
`define TWT_SC_GC_NAK  8'h98
`define TWT_SC_STOP    8'hA0
`define TWT_SC_TXA_OWN 8'hA8
`define TWT_SC_TXA_ARB 8'hB0
`define TWT_SC_TX_ACK  8'hB8
`define TWT_SC_TX_NAK  8'hC0
`define TWT_SC_TX_LST  8'hC8
`define TWT_SC_NONE    8'hF8
`define TWT_GC_ADDR    7'h00
`define TWT_RST_BYTE   8'h00
`define TWT_BITS_BYTE  4'h8
`define TWT_LAST_BIT   4'h7

`endif

// ==== twt_pkg.sv ====
// Types of the two-wire target block.
// Assumes twt_cfg.svh is on the include path.
package twt_pkg;

  // -----------------------------------------------------------------------
  // Register port request and bus pin drive
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } twt_regreq_t;

  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } twt_pins_t;

  // -----------------------------------------------------------------------
  // Engine states and the action due when the flag is cleared
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TWT_IDLE = 3'b000,
    TWT_ADDR = 3'b001,
    TWT_AACK = 3'b011,
    TWT_WAIT = 3'b010,
    TWT_RXD  = 3'b110,
    TWT_RACK = 3'b111,
    TWT_TXD  = 3'b101,
    TWT_TACK = 3'b100
  } twt_state_t;

  typedef enum logic [1:0] {
    TWT_NA_RX  = 2'b00,
    TWT_NA_TX  = 2'b01,
    TWT_NA_END = 2'b11
  } twt_next_t;

endpackage

// ==== twt_target.sv ====
// Two-wire bus target: address match, receive and transmit as target,
// software handshake through the job flag, clock stretching and wake-up.
// Assumes SCL_IN and SDA_IN come straight from the pins, all other inputs
// come from logic on CLK_IN, and the pins are open drain.
// Matching needs the job flag clear; a stretched clock waits on software.
// While asleep no received byte reaches the data register.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "twt_cfg.svh"

module twt_target (
  input  wire logic              CLK_IN,
  input  wire logic              RESET_IN,
  input  wire twt_pkg::twt_regreq_t REG_REQ_IN,
  output logic [7:0]             REG_RDATA_OUT,
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output twt_pkg::twt_pins_t     PINS_OUT,
  input  wire logic              ARB_LOST_IN,
  input  wire logic              SLEEP_IN,
  output logic                   WAKE_OUT,
  output logic                   START_GO_OUT
);
  import twt_pkg::*;

  // -----------------------------------------------------------------------
  // State record
  // -----------------------------------------------------------------------
  typedef struct packed {
    // Engine and bus sampling
    twt_state_t st;
    twt_next_t  next_act;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_d;
    logic       sda_d;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       ack_byte;
    logic       tx_last;
    logic       dir_rd;
    logic       gc;
    logic       m_ack;
    logic       rx_addr;
    logic       sda_low;
    logic       scl_hold;
    // Software-visible registers
    logic       flag;
    logic       ack_en;
    logic       sta;
    logic       sto;
    logic       wc;
    logic       en;
    logic       ie;
    logic [7:0] own_addr;
    logic [7:0] data;
    logic [7:0] status;
    // Bus watch, pulses and read data
    logic       busy;
    logic       start_pend;
    logic       start_go;
    logic       wake;
    logic [7:0] rdata;
  } twt_st_t;

  twt_st_t r;
  twt_st_t n;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic clear_ev;

  // -----------------------------------------------------------------------
  // Status code for an acknowledged address
  // -----------------------------------------------------------------------
  function automatic logic [7:0] addr_code(input logic rd, input logic gcm, input logic arb);
    if (rd) begin
      addr_code = arb ? `TWT_SC_TXA_ARB : `TWT_SC_TXA_OWN;
    end else if (gcm) begin
      addr_code = arb ? `TWT_SC_GC_ARB : `TWT_SC_GC;
    end else begin
      addr_code = arb ? `TWT_SC_RXA_ARB : `TWT_SC_RXA_OWN;
    end
  endfunction

  // -----------------------------------------------------------------------
  // Bus conditions seen through the second synchroniser stage
  // -----------------------------------------------------------------------
  assign scl      = r.scl_s[1];
  assign sda      = r.sda_s[1];
  assign scl_rise = scl & ~r.scl_d;
  assign scl_fall = ~scl & r.scl_d;
  assign start_c  = scl & r.scl_d & r.sda_d & ~sda;
  assign stop_c   = scl & r.scl_d & ~r.sda_d & sda;
  assign clear_ev = REG_REQ_IN.wr & (REG_REQ_IN.addr == `TWT_OFS_CTRL)
                  & REG_REQ_IN.wdata[`TWT_CB_FLAG] & r.flag;

  // -----------------------------------------------------------------------
  // Next-state logic: one copy of the record, filled each cycle
  // -----------------------------------------------------------------------
  always_comb begin
    logic own_m;
    logic gc_m;
    own_m = 1'b0;
    gc_m  = 1'b0;
    n = r;
    n.scl_s    = {r.scl_s[0], SCL_IN};
    n.sda_s    = {r.sda_s[0], SDA_IN};
    n.scl_d    = scl;
    n.sda_d    = sda;
    n.start_go = 1'b0;
    n.wake     = 1'b0;
    n.rdata    = `TWT_RST_BYTE;

    // ---------------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------------
    if (REG_REQ_IN.rd) begin
      unique case (REG_REQ_IN.addr)
        `TWT_OFS_CTRL: n.rdata = {r.flag, r.ack_en, r.sta, r.sto, r.wc, r.en, 1'b0, r.ie};
        `TWT_OFS_STAT: n.rdata = r.flag ? r.status : `TWT_SC_NONE;
        `TWT_OFS_DATA: n.rdata = r.data;
        `TWT_OFS_OWN:  n.rdata = r.own_addr;
      endcase
    end
    if (REG_REQ_IN.wr) begin
      unique case (REG_REQ_IN.addr)
        `TWT_OFS_CTRL: begin
          n.ack_en = REG_REQ_IN.wdata[`TWT_CB_ACKEN];
          n.sta    = REG_REQ_IN.wdata[`TWT_CB_STA];
          n.sto    = REG_REQ_IN.wdata[`TWT_CB_STO];
          n.wc     = REG_REQ_IN.wdata[`TWT_CB_WC] & r.wc;
          n.en     = REG_REQ_IN.wdata[`TWT_CB_EN];
          n.ie     = REG_REQ_IN.wdata[`TWT_CB_IE];
          if (clear_ev) begin
            n.flag = 1'b0;
          end
        end
        `TWT_OFS_STAT: begin
        end
        // Data written without the flag is refused and flags a collision
        `TWT_OFS_DATA: begin
          if (r.flag) begin
            n.data = REG_REQ_IN.wdata;
          end else begin
            n.wc = 1'b1;
          end
        end
        `TWT_OFS_OWN:  n.own_addr = REG_REQ_IN.wdata;
      endcase
    end

    // ---------------------------------------------------------------------
    // Bus state and queued START
    // ---------------------------------------------------------------------
    if (start_c) begin
      n.busy = 1'b1;
    end else if (stop_c) begin
      n.busy = 1'b0;
    end
    if (clear_ev && r.next_act == TWT_NA_END) begin
      n.rx_addr = 1'b0;
      if (n.sta) begin
        n.start_pend = 1'b1;
      end
    end
    // A queued START waits until a STOP has freed the bus
    if (r.start_pend && !r.busy) begin
      n.start_go   = 1'b1;
      n.start_pend = 1'b0;
    end

    // ---------------------------------------------------------------------
    // Transfer engine
    // ---------------------------------------------------------------------
    if (!r.en) begin
      n.st       = TWT_IDLE;
      n.sda_low  = 1'b0;
      n.scl_hold = 1'b0;
      n.rx_addr  = 1'b0;
    end else if ((start_c || stop_c) && r.st != TWT_WAIT) begin
      if (r.rx_addr && r.st == TWT_RXD) begin
        n.flag     = 1'b1;
        n.status   = `TWT_SC_STOP;
        n.next_act = TWT_NA_END;
        n.rx_addr  = 1'b0;
      end
      n.st      = start_c ? TWT_ADDR : TWT_IDLE;
      n.cnt     = 4'h0;
      n.sda_low = 1'b0;
    end else begin
      unique case (r.st)

        // Not addressed: SDA stays released whatever the master clocks
        TWT_IDLE: begin
          n.sda_low = 1'b0;
        end
        // -------------------------------------------------------------------
        // Address byte and match
        // -------------------------------------------------------------------
        TWT_ADDR: begin
          if (scl_rise) begin
            n.sh  = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end
          if (scl_fall && r.cnt == `TWT_BITS_BYTE) begin
            own_m = (r.sh[7:1] == r.own_addr[7:1]);
            gc_m  = (r.sh[7:1] == `TWT_GC_ADDR) & r.own_addr[`TWT_OWN_GCE] & ~r.sh[0];
            // Live ack enable gates both matches; bus stays watched anyway
            if (r.ack_en && !r.flag && (own_m || gc_m)) begin
              n.sda_low = 1'b1;
              n.gc      = gc_m;
              n.dir_rd  = r.sh[0];
              n.st      = TWT_AACK;
            end else begin
              n.st = TWT_IDLE;
            end
          end
        end

        // Acknowledge slot: flag, status and clock hold come together
        TWT_AACK: begin
          if (scl_fall) begin
            n.sda_low  = 1'b0;
            n.flag     = 1'b1;
            n.scl_hold = 1'b1;
            n.status   = addr_code(r.dir_rd, r.gc, ARB_LOST_IN);
            n.next_act = r.dir_rd ? TWT_NA_TX : TWT_NA_RX;
            n.rx_addr  = ~r.dir_rd;
            n.wake     = SLEEP_IN;
            n.st       = TWT_WAIT;
          end
        end
        // -------------------------------------------------------------------
        // Software handshake
        // -------------------------------------------------------------------
        TWT_WAIT: begin
          if (clear_ev) begin
            n.scl_hold = 1'b0;
            n.cnt      = 4'h0;
            unique case (r.next_act)
              TWT_NA_RX: begin
                n.ack_byte = n.ack_en;
                n.st       = TWT_RXD;
              end
              TWT_NA_TX: begin
                n.sh      = n.data;
                n.tx_last = ~n.ack_en;
                n.sda_low = ~n.data[7];
                n.st      = TWT_TXD;
              end
              TWT_NA_END: begin
                n.st = TWT_IDLE;
              end
              default: begin
                n.st = TWT_IDLE;
              end
            endcase
          end
        end
        // -------------------------------------------------------------------
        // Data byte in
        // -------------------------------------------------------------------
        TWT_RXD: begin
          if (scl_rise) begin
            n.sh  = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end
          if (scl_fall && r.cnt == `TWT_BITS_BYTE) begin
            n.sda_low = r.ack_byte;
            n.st      = TWT_RACK;
          end
        end

        // Asleep, the shifted byte is kept out of the data register
        TWT_RACK: begin
          if (scl_fall) begin
            n.sda_low  = 1'b0;
            n.flag     = 1'b1;
            n.scl_hold = 1'b1;
            if (!SLEEP_IN) begin
              n.data = r.sh;
            end
            if (r.gc) begin
              n.status = r.ack_byte ? `TWT_SC_GC_ACK : `TWT_SC_GC_NAK;
            end else begin
              n.status = r.ack_byte ? `TWT_SC_RX_ACK : `TWT_SC_RX_NAK;
            end
            n.next_act = r.ack_byte ? TWT_NA_RX : TWT_NA_END;
            n.st       = TWT_WAIT;
          end
        end
        // -------------------------------------------------------------------
        // Data byte out
        // -------------------------------------------------------------------
        // Next bit moves a few clocks after the fall, long before the rise
        TWT_TXD: begin
          if (scl_fall) begin
            if (r.cnt == `TWT_LAST_BIT) begin
              n.sda_low = 1'b0;
              n.st      = TWT_TACK;
            end else begin
              n.sda_low = ~r.sh[6];
              n.sh      = {r.sh[6:0], 1'b1};
              n.cnt     = r.cnt + 4'h1;
            end
          end
        end

        // Master answer is taken at the rise, acted on at the fall
        TWT_TACK: begin
          if (scl_rise) begin
            n.m_ack = ~sda;
          end
          if (scl_fall) begin
            n.flag     = 1'b1;
            n.scl_hold = 1'b1;
            if (!r.m_ack) begin
              n.status = `TWT_SC_TX_NAK;
            end else if (r.tx_last) begin
              n.status = `TWT_SC_TX_LST;
            end else begin
              n.status = `TWT_SC_TX_ACK;
            end
            // After the last byte the engine idles with SDA released
            n.next_act = (r.m_ack && !r.tx_last) ? TWT_NA_TX : TWT_NA_END;
            n.st       = TWT_WAIT;
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      r          <= '0;
      r.st       <= TWT_IDLE;
      r.next_act <= TWT_NA_END;
      r.scl_s    <= 2'h3;
      r.sda_s    <= 2'h3;
      r.scl_d    <= 1'b1;
      r.sda_d    <= 1'b1;
      r.busy     <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign REG_RDATA_OUT     = r.rdata;
  // Open drain: only the enables move
  assign PINS_OUT.scl_out  = 1'b0;
  assign PINS_OUT.scl_oe_n = ~r.scl_hold;
  assign PINS_OUT.sda_out  = 1'b0;
  assign PINS_OUT.sda_oe_n = ~r.sda_low;
  assign WAKE_OUT          = r.wake;
  assign START_GO_OUT      = r.start_go;

endmodule

// ==== twt_i2c_master.sv ====
// I2C bus master model: start, stop, byte out and byte in.
// Assumes the bench forms both wire levels from pull-ups and all releases.
`timescale 1ns/10ps
module twt_i2c_master (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rel_out,
  output logic      sda_rel_out,
  output logic      to_out
);
  // ---------------------------------------------------------------------
  // Bus cycles: 125 ns low, 75 ns high
  // ---------------------------------------------------------------------
  initial begin
    scl_rel_out = 1'b1;
    sda_rel_out = 1'b1;
    to_out      = 1'b0;
  end
  task automatic wait_high();
    scl_rel_out = 1'b1;
    for (int i = 0; i < 4000 && scl_in !== 1'b1; i++) #5;
    if (scl_in !== 1'b1) to_out = 1'b1;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_rel_out = b;
    #60 wait_high();
    #40 s = sda_in;
    #35 scl_rel_out = 1'b0;
    #65;
  endtask
  task automatic start();
    sda_rel_out = 1'b1;
    scl_rel_out = 1'b1;
    #100 sda_rel_out = 1'b0;
    #100 scl_rel_out = 1'b0;
    #65;
  endtask
  task automatic stop();
    sda_rel_out = 1'b0;
    #60 wait_high();
    #75 sda_rel_out = 1'b1;
    #100;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!ack, s);
  endtask
endmodule

// ==== twt_target_sva.sv ====
// Port assertions of the two-wire target.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/10ps
module twt_target_sva (
  input wire logic                 CLK_IN,
  input wire logic                 RESET_IN,
  input wire twt_pkg::twt_regreq_t REG_REQ_IN,
  input wire logic [7:0]           REG_RDATA_OUT,
  input wire logic                 SCL_IN,
  input wire logic                 SDA_IN,
  input wire twt_pkg::twt_pins_t   PINS_OUT,
  input wire logic                 ARB_LOST_IN,
  input wire logic                 SLEEP_IN,
  input wire logic                 WAKE_OUT,
  input wire logic                 START_GO_OUT
);
  import twt_pkg::*;
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  logic clr;
  assign clr = REG_REQ_IN.wr && REG_REQ_IN.addr == 2'h0 && REG_REQ_IN.wdata[7];
  property p_rd_quiet;
    !REG_REQ_IN.rd |=> REG_RDATA_OUT == 8'h00;
  endproperty
  property p_od_low;
    PINS_OUT.scl_out == 1'b0 && PINS_OUT.sda_out == 1'b0;
  endproperty
  property p_code_align;
    REG_REQ_IN.rd && REG_REQ_IN.addr == 2'h1 |=> REG_RDATA_OUT[2:0] == 3'h0;
  endproperty
  property p_wake_sleep;
    WAKE_OUT |-> $past(SLEEP_IN) ##1 !WAKE_OUT;
  endproperty
  property p_wake_hold;
    WAKE_OUT |-> ##[0:3] !PINS_OUT.scl_oe_n;
  endproperty
  property p_hold_scl;
    !PINS_OUT.scl_oe_n && !clr && !$past(clr) |=> !PINS_OUT.scl_oe_n;
  endproperty
  property p_release;
    clr && !PINS_OUT.scl_oe_n |-> ##[1:2] PINS_OUT.scl_oe_n;
  endproperty
  property p_sda_scl_low;
    $changed(PINS_OUT.sda_oe_n) |-> !$past(SCL_IN);
  endproperty
  property p_start_go;
    START_GO_OUT |-> PINS_OUT.scl_oe_n ##1 !START_GO_OUT;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
  a_od_low: assert property (p_od_low) else $error("pin driven high");
  a_code_align: assert property (p_code_align) else $error("status low bits set");
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
  a_wake_hold: assert property (p_wake_hold) else $error("no hold at wake");
  a_hold_scl: assert property (p_hold_scl) else $error("clock hold dropped");
  a_release: assert property (p_release) else $error("clock hold kept");
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved with clock high");
  a_start_go: assert property (p_start_go) else $error("bad start pulse");
  c_wake: cover property (WAKE_OUT);
  c_go: cover property (START_GO_OUT);
  c_hold: cover property ($fell(PINS_OUT.scl_oe_n));
endmodule

bind twt_target twt_target_sva twt_target_sva_inst (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .REG_REQ_IN(REG_REQ_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .PINS_OUT(PINS_OUT), .ARB_LOST_IN(ARB_LOST_IN),
  .SLEEP_IN(SLEEP_IN), .WAKE_OUT(WAKE_OUT), .START_GO_OUT(START_GO_OUT)
);

// ==== twt_target_tb_top.sv ====
// Self-checking bench of the two-wire target driven by an I2C master model.
// Assumes package, design, checker and master model are compiled before it.
`timescale 1ns/10ps
module twt_target_tb_top;
  import twt_pkg::*;
  // ---------------------------------------------------------------------
  // Wiring and access tasks
  // ---------------------------------------------------------------------
  localparam logic [6:0] ADDR = 7'h2D;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  twt_regreq_t req = '0;
  logic [7:0]  rdata;
  twt_pins_t   pins;
  logic        arb = 1'b0;
  logic        sleep = 1'b0;
  logic        wake, go, m_scl, m_sda, m_to;
  wire         scl_w = m_scl & pins.scl_oe_n;
  wire         sda_w = m_sda & pins.sda_oe_n;
  int          errors = 0;
  int          checked = 0;
  int          wakes = 0;
  int          gos = 0;
  always #12.5 clk_in = !clk_in;
  always @(posedge clk_in) begin
    if (wake === 1'b1) wakes++;
    if (go === 1'b1) gos++;
  end
  always @(posedge m_to) begin
    errors++;
    test_done();
  end
  twt_target twt_target_inst (.CLK_IN(clk_in), .RESET_IN(reset_in), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
    .SCL_IN(scl_w), .SDA_IN(sda_w), .PINS_OUT(pins), .ARB_LOST_IN(arb), .SLEEP_IN(sleep),
    .WAKE_OUT(wake), .START_GO_OUT(go));
  twt_i2c_master twt_i2c_master_inst (.scl_in(scl_w), .sda_in(sda_w), .scl_rel_out(m_scl),
    .sda_rel_out(m_sda), .to_out(m_to));
  task automatic test_done();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in) req <= '0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in) req <= '0;
    #1 d = rdata;
  endtask
  task automatic wait_flag(input logic [7:0] c);
    logic [7:0] d;
    d = 8'hF8;
    for (int i = 0; i < 300 && d === 8'hF8; i++) rd(2'h1, d);
    chk("status", c, d);
    if (d === 8'hF8) test_done();
  endtask
  task automatic tx(input logic [7:0] d, input logic e);
    logic k;
    twt_i2c_master_inst.send_byte(d, k);
    chk("ack", {7'h0, e}, {7'h0, k});
  endtask
  task automatic sa(input logic [7:0] a, input logic e);
    twt_i2c_master_inst.start();
    tx(a, e);
  endtask
  task automatic rx(input logic [7:0] e, input logic a);
    logic [7:0] d;
    twt_i2c_master_inst.recv_byte(d, a);
    chk("tx byte", e, d);
  endtask
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(2'h0, d);
    chk("ctrl reset", 8'h00, d);
    rd(2'h3, d);
    chk("own reset", 8'h00, d);
    wr(2'h1, 8'hFF);
    rd(2'h1, d);
    chk("status idle", 8'hF8, d);
    wr(2'h0, 8'h46);
    wr(2'h2, 8'h11);
    rd(2'h0, d);
    chk("ctrl collision", 8'h4C, d);
    wr(2'h0, 8'h44);
    wr(2'h3, {ADDR, 1'b0});
    sa(8'h00, 1'b0);
    twt_i2c_master_inst.stop();
    sa({ADDR ^ 7'h01, 1'b0}, 1'b0);
    twt_i2c_master_inst.stop();
    sa({ADDR, 1'b0}, 1'b1);
    wait_flag(8'h60);
    wr(2'h0, 8'hC4);
    tx(8'hA5, 1'b1);
    wait_flag(8'h80);
    rd(2'h2, d);
    chk("rx data", 8'hA5, d);
    wr(2'h0, 8'h84);
    tx(8'h3C, 1'b0);
    wait_flag(8'h88);
    wr(2'h0, 8'hE4);
    twt_i2c_master_inst.stop();
    for (int i = 0; i < 200 && gos == 0; i++) @(posedge clk_in);
    chk("start go", 8'h01, gos[7:0]);
    wr(2'h0, 8'h44);
    wr(2'h3, {ADDR, 1'b1});
    sa(8'h00, 1'b1);
    wait_flag(8'h70);
    wr(2'h0, 8'hC4);
    tx(8'h96, 1'b1);
    wait_flag(8'h90);
    wr(2'h0, 8'h84);
    tx(8'h69, 1'b0);
    wait_flag(8'h98);
    wr(2'h0, 8'hC4);
    twt_i2c_master_inst.stop();
    wr(2'h0, 8'h04);
    sa({ADDR, 1'b0}, 1'b0);
    twt_i2c_master_inst.stop();
    wr(2'h0, 8'h44);
    @(posedge clk_in) sleep <= 1'b1;
    sa({ADDR, 1'b0}, 1'b1);
    wait_flag(8'h60);
    chk("wakes", 8'h01, wakes[7:0]);
    chk("scl held", 8'h00, {7'h0, pins.scl_oe_n});
    @(posedge clk_in) sleep <= 1'b0;
    wr(2'h0, 8'hC4);
    twt_i2c_master_inst.stop();
    wait_flag(8'hA0);
    wr(2'h0, 8'hC4);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in) arb <= (k == 0);
      sa({ADDR, 1'b1}, 1'b1);
      wait_flag(k ? 8'hA8 : 8'hB0);
      @(posedge clk_in) arb <= 1'b0;
      wr(2'h2, 8'hC3);
      wr(2'h0, 8'hC4);
      rx(8'hC3, 1'b1);
      wait_flag(8'hB8);
      wr(2'h2, 8'h5A);
      wr(2'h0, 8'h84);
      rx(8'h5A, k[0]);
      wait_flag(k ? 8'hC8 : 8'hC0);
      wr(2'h0, 8'hC4);
      if (k == 1) rx(8'hFF, 1'b0);
      twt_i2c_master_inst.stop();
    end
    test_done();
  end
endmodule
